// >>> verilog/gpio_port_pkg.sv
// shared constants, register map and pin-to-segment decoding for the port block
package gpio_port_pkg;

  localparam int PIN_COUNT = 8;
  localparam int DATA_W    = 32;
  localparam int ADDR_W    = 12;
  localparam int REG_W     = 8;

  localparam logic [ADDR_W-1:0] ADDR_PIN_STATE  = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_OUT_LATCH  = 12'h004;
  localparam logic [ADDR_W-1:0] ADDR_DIRECTION  = 12'h008;
  localparam logic [ADDR_W-1:0] ADDR_PORT_G     = 12'h00C;
  localparam logic [ADDR_W-1:0] ADDR_SEG_ENABLE = 12'h010;

  localparam logic [REG_W-1:0] RST_DIRECTION  = 8'hFF;
  localparam logic [REG_W-1:0] RST_OUT_LATCH  = 8'h00;
  localparam logic [REG_W-1:0] RST_SEG_ENABLE = 8'h00;
  localparam logic             RST_PULLUP     = 1'b0;
  localparam logic [REG_W-1:0] ZERO_BYTE      = 8'h00;
  localparam logic [DATA_W-1:0] ZERO_WORD     = 32'h0000_0000;

  localparam int SHARED_PULLUP_BIT = 5;
  localparam int LANE0             = 0;

  // segment-enable bit that owns each pin; pin 0 has none
  localparam logic [2:0] SEG_BIT_PIN1 = 3'h1;
  localparam logic [2:0] SEG_BIT_PIN2 = 3'h2;
  localparam logic [2:0] SEG_BIT_PIN3 = 3'h3;
  localparam logic [2:0] SEG_BIT_PIN4 = 3'h7;
  localparam logic [2:0] SEG_BIT_PIN5 = 3'h6;
  localparam logic [2:0] SEG_BIT_PIN6 = 3'h5;
  localparam logic [2:0] SEG_BIT_PIN7 = 3'h4;
  localparam logic [2:0] SEG_BIT_NONE = 3'h0;

  typedef enum logic [2:0] {
    SEL_PIN_STATE,
    SEL_OUT_LATCH,
    SEL_DIRECTION,
    SEL_PORT_G,
    SEL_SEG_ENABLE,
    SEL_NONE
  } reg_sel_t;

  function automatic reg_sel_t decodeAddr(input logic [ADDR_W-1:0] addr);
    case (addr)
      ADDR_PIN_STATE:  decodeAddr = SEL_PIN_STATE;
      ADDR_OUT_LATCH:  decodeAddr = SEL_OUT_LATCH;
      ADDR_DIRECTION:  decodeAddr = SEL_DIRECTION;
      ADDR_PORT_G:     decodeAddr = SEL_PORT_G;
      ADDR_SEG_ENABLE: decodeAddr = SEL_SEG_ENABLE;
      default:         decodeAddr = SEL_NONE;
    endcase
  endfunction

  function automatic logic [2:0] segBitForPin(input int pin);
    case (pin)
      1:       segBitForPin = SEG_BIT_PIN1;
      2:       segBitForPin = SEG_BIT_PIN2;
      3:       segBitForPin = SEG_BIT_PIN3;
      4:       segBitForPin = SEG_BIT_PIN4;
      5:       segBitForPin = SEG_BIT_PIN5;
      6:       segBitForPin = SEG_BIT_PIN6;
      7:       segBitForPin = SEG_BIT_PIN7;
      default: segBitForPin = SEG_BIT_NONE;
    endcase
  endfunction

  function automatic logic pinHasSegment(input int pin);
    pinHasSegment = (pin != 0);
  endfunction

endpackage

// >>> verilog/pin_mux.sv
// per-pin selection between segment drive, port output and input with pull-up
`timescale 1ns/1ps
module pin_mux (
  input  wire logic segEnable,
  input  wire logic segLevel,
  input  wire logic dirInput,
  input  wire logic latchBit,
  input  wire logic pullupShared,
  output logic      driveLevel,
  output logic      driveEnable,
  output logic      pullupOn,
  output logic      segmentActive
);

  always_comb begin
    segmentActive = segEnable;
    if (segEnable) begin
      // segment wins whatever the direction bit says
      driveLevel  = segLevel;
      driveEnable = 1'b1;
      pullupOn    = 1'b0;
    end else begin
      driveLevel  = latchBit;
      driveEnable = ~dirInput;
      pullupOn    = pullupShared & dirInput;
    end
  end

endmodule

// >>> verilog/gpio_port_j.sv
// eight-pin port with latch, direction, segment sharing and shared pull-ups on APB
//
// Implementation choices: the address map and the APB register port.
`timescale 1ns/1ps

// Notes on behaviour
// - the port has eight pins with a pin-state, an output-latch and a direction register.
// - direction 0 drives the pin from its latch bit, direction 1 makes it an input read back.
// - any reset makes every pin a digital input.
// - pins 1 to 7 share segment outputs enabled by segment-enable bits, pin 0 has none.
// - an enabled segment overrides the pin; pins 1-3 take segments 33-35, pins 4-7 take 39-36.
// - all pull-ups are switched together by bit 5 of the port G register.
// - a pin set as output has its pull-up off even while the shared enable is set.
// - any reset leaves all pull-ups disabled.
// - on variants without the port the shared pull-up bit reads as zero.
// - writing the pin-state register writes the output latch.
module gpio_port_j #(
  parameter bit PORT_PRESENT = 1'b1
) (
  input  wire logic                            clock,
  input  wire logic                            sys_rst,
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [gpio_port_pkg::ADDR_W-1:0] paddr,
  input  wire logic [gpio_port_pkg::DATA_W-1:0] pwdata,
  input  wire logic [3:0]                      pstrb,
  output logic      [gpio_port_pkg::DATA_W-1:0] prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  input  wire logic [gpio_port_pkg::REG_W-1:0]  pinIn,
  output logic      [gpio_port_pkg::REG_W-1:0]  pinOut,
  output logic      [gpio_port_pkg::REG_W-1:0]  pinOe,
  output logic      [gpio_port_pkg::REG_W-1:0]  pullupOn,
  input  wire logic [gpio_port_pkg::REG_W-1:0]  segmentDrive,
  output logic      [gpio_port_pkg::REG_W-1:0]  segmentActive
);
  import gpio_port_pkg::*;

  // software-visible register state
  logic [REG_W-1:0] latch_reg;
  logic [REG_W-1:0] latch_next;
  logic [REG_W-1:0] direction_reg;
  logic [REG_W-1:0] direction_next;
  logic [REG_W-1:0] segEnable_reg;
  logic [REG_W-1:0] segEnable_next;
  logic             pullupShared_reg;
  logic             pullupShared_next;

  // bus answer state
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic              ready_reg;
  logic              ready_next;
  logic              slverr_reg;
  logic              slverr_next;

  // registered pin outputs
  logic [REG_W-1:0] pinOut_reg;
  logic [REG_W-1:0] pinOut_next;
  logic [REG_W-1:0] pinOe_reg;
  logic [REG_W-1:0] pinOe_next;
  logic [REG_W-1:0] pullup_reg;
  logic [REG_W-1:0] pullup_next;
  logic [REG_W-1:0] segActive_reg;
  logic [REG_W-1:0] segActive_next;

  // bus decode
  reg_sel_t         sel;
  logic             setupPhase;
  logic             accessDone;
  logic             lateAccess;
  logic             writeDone;
  logic             laneZero;
  logic [REG_W-1:0] wrByte;
  logic             sharedBitView;
  logic [REG_W-1:0] portGView;
  logic [REG_W-1:0] readByte;

  assign sel        = decodeAddr(paddr);
  assign setupPhase = psel & ~penable;
  assign accessDone = psel & penable & ready_reg;
  assign lateAccess = psel & penable & ~ready_reg;
  assign laneZero   = pstrb[LANE0];
  assign writeDone  = accessDone & pwrite & laneZero;
  assign wrByte     = pwdata[REG_W-1:0];

  // shared pull-up bit only exists where the port is fitted
  assign sharedBitView = PORT_PRESENT ? pullupShared_reg : 1'b0;

  always_comb begin
    portGView                    = ZERO_BYTE;
    portGView[SHARED_PULLUP_BIT] = sharedBitView;
  end

  // write strobe of one register, true only at the completing access edge
  function automatic logic hitsReg(input reg_sel_t want, input reg_sel_t got, input logic done);
    hitsReg = done && (got == want);
  endfunction

  // output latch: the pin-state word and the latch word land in the same flops
  always_comb begin
    latch_next = latch_reg;
    if (hitsReg(SEL_PIN_STATE, sel, writeDone)) begin
      latch_next = wrByte;
    end else if (hitsReg(SEL_OUT_LATCH, sel, writeDone)) begin
      latch_next = wrByte;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      latch_reg <= RST_OUT_LATCH;
    end else begin
      latch_reg <= latch_next;
    end
  end

  // direction: a set bit makes the pin an input
  always_comb begin
    direction_next = direction_reg;
    if (hitsReg(SEL_DIRECTION, sel, writeDone)) begin
      direction_next = wrByte;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      direction_reg <= RST_DIRECTION;
    end else begin
      direction_reg <= direction_next;
    end
  end

  // segment enables; bit 0 is stored but owns no pin
  always_comb begin
    segEnable_next = segEnable_reg;
    if (hitsReg(SEL_SEG_ENABLE, sel, writeDone)) begin
      segEnable_next = wrByte;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      segEnable_reg <= RST_SEG_ENABLE;
    end else begin
      segEnable_reg <= segEnable_next;
    end
  end

  // shared pull-up enable; without the port the bit stays cleared
  always_comb begin
    pullupShared_next = pullupShared_reg;
    if (PORT_PRESENT && hitsReg(SEL_PORT_G, sel, writeDone)) begin
      pullupShared_next = wrByte[SHARED_PULLUP_BIT];
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pullupShared_reg <= RST_PULLUP;
    end else begin
      pullupShared_reg <= pullupShared_next;
    end
  end

  // read-back multiplexer
  always_comb begin
    case (sel)
      SEL_PIN_STATE:  readByte = pinIn;
      SEL_OUT_LATCH:  readByte = latch_reg;
      SEL_DIRECTION:  readByte = direction_reg;
      SEL_PORT_G:     readByte = portGView;
      SEL_SEG_ENABLE: readByte = segEnable_reg;
      default:        readByte = ZERO_BYTE;
    endcase
  end

  // handshake flag rises during setup, so every access completes on its first edge
  always_comb begin
    ready_next = 1'b0;
    if (setupPhase || lateAccess) begin
      ready_next = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ready_reg <= 1'b0;
    end else begin
      ready_reg <= ready_next;
    end
  end

  // error flag travels with the handshake flag and marks unmapped words
  always_comb begin
    slverr_next = 1'b0;
    if (setupPhase || lateAccess) begin
      slverr_next = (sel == SEL_NONE);
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      slverr_reg <= 1'b0;
    end else begin
      slverr_reg <= slverr_next;
    end
  end

  // read data is captured during setup and cleared once the access completes
  always_comb begin
    rdata_next = rdata_reg;
    if (setupPhase) begin
      rdata_next = ZERO_WORD;
      if (!pwrite) begin
        rdata_next[REG_W-1:0] = readByte;
      end
    end else if (accessDone) begin
      rdata_next = ZERO_WORD;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_reg <= ZERO_WORD;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign prdata  = rdata_reg;
  assign pready  = ready_reg;
  assign pslverr = slverr_reg;

  // per-pin choice of segment, port drive and pull-up
  logic [REG_W-1:0] muxLevel;
  logic [REG_W-1:0] muxEnable;
  logic [REG_W-1:0] muxPullup;
  logic [REG_W-1:0] muxSegment;

  generate
    for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
      logic segEn;
      logic segLvl;
      if (pinHasSegment(i)) begin : g_seg
        assign segEn  = segEnable_reg[segBitForPin(i)];
        assign segLvl = segmentDrive[segBitForPin(i)];
      end else begin : g_noseg
        assign segEn  = 1'b0;
        assign segLvl = 1'b0;
      end
      pin_mux u_pin_mux (
        .segEnable     (segEn),
        .segLevel      (segLvl),
        .dirInput      (direction_reg[i]),
        .latchBit      (latch_reg[i]),
        .pullupShared  (sharedBitView),
        .driveLevel    (muxLevel[i]),
        .driveEnable   (muxEnable[i]),
        .pullupOn      (muxPullup[i]),
        .segmentActive (muxSegment[i])
      );
    end
  endgenerate

  // pin drive: level and enable register together so they change on one edge
  always_comb begin
    pinOut_next = muxLevel;
    pinOe_next  = muxEnable;
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pinOut_reg <= ZERO_BYTE;
      pinOe_reg  <= ZERO_BYTE;
    end else begin
      pinOut_reg <= pinOut_next;
      pinOe_reg  <= pinOe_next;
    end
  end

  // pull-ups: off in reset, then follow the shared enable and the direction, and stay off on pins a segment owns
  always_comb begin
    pullup_next = muxPullup;
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pullup_reg <= ZERO_BYTE;
    end else begin
      pullup_reg <= pullup_next;
    end
  end

  // segment ownership as seen on the pins
  always_comb begin
    segActive_next = muxSegment;
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      segActive_reg <= ZERO_BYTE;
    end else begin
      segActive_reg <= segActive_next;
    end
  end

  assign pinOut        = pinOut_reg;
  assign pinOe         = pinOe_reg;
  assign pullupOn      = pullup_reg;
  assign segmentActive = segActive_reg;

endmodule

// >>> dv/gpio_port_j_sva.sv
// assertions on the port block's bus and pin outputs
`timescale 1ns/1ps
module gpio_port_j_sva
  import gpio_port_pkg::*;
#(parameter bit PORT_PRESENT = 1'b1) (
  input wire logic                               clock,
  input wire logic                               sys_rst,
  input wire logic                               psel,
  input wire logic                               penable,
  input wire logic                               pwrite,
  input wire logic [gpio_port_pkg::ADDR_W-1:0]   paddr,
  input wire logic [gpio_port_pkg::DATA_W-1:0]   pwdata,
  input wire logic [3:0]                         pstrb,
  input wire logic [gpio_port_pkg::DATA_W-1:0]   prdata,
  input wire logic                               pready,
  input wire logic                               pslverr,
  input wire logic [gpio_port_pkg::REG_W-1:0]    pinIn,
  input wire logic [gpio_port_pkg::REG_W-1:0]    pinOut,
  input wire logic [gpio_port_pkg::REG_W-1:0]    pinOe,
  input wire logic [gpio_port_pkg::REG_W-1:0]    pullupOn,
  input wire logic [gpio_port_pkg::REG_W-1:0]    segmentDrive,
  input wire logic [gpio_port_pkg::REG_W-1:0]    segmentActive
);
  logic [7:0] segMap;
  logic       mapped;
  // segment level as seen on each pin, pin 0 has none
  assign segMap = {segmentDrive[4], segmentDrive[5], segmentDrive[6], segmentDrive[7],
                   segmentDrive[3:1], 1'b0};
  assign mapped = paddr <= ADDR_SEG_ENABLE && paddr[1:0] == 2'h0;
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  rdy_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("no ready in access cycle");
  rdy_single_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  err_unmapped_a: assert property (psel && !penable |=> pslverr == !$past(mapped))
    else $error("error flag wrong for address");
  rd_pins_a: assert property (psel && !penable && !pwrite && paddr == ADDR_PIN_STATE
    |=> prdata == {24'h0, $past(pinIn)})
    else $error("pin state read wrong");
  rst_inputs_a: assert property ($fell(sys_rst) |-> (pinOe | pullupOn | segmentActive) == 0)
    else $error("outputs not idle after reset");
  seg_pin0_a: assert property (segmentActive[0] == 1'b0)
    else $error("pin 0 taken by a segment");
  seg_drive_a: assert property ((pinOe & segmentActive) == segmentActive
    && (pinOut & segmentActive) == ($past(segMap) & segmentActive))
    else $error("segment does not drive pin");
  pu_off_out_a: assert property ((pullupOn & (pinOe | segmentActive)) == 8'h00)
    else $error("pull-up on driven pin");
  pu_absent_a: assert property (pullupOn != 8'h00 |-> PORT_PRESENT)
    else $error("pull-up on without port");
endmodule

bind gpio_port_j gpio_port_j_sva #(.PORT_PRESENT(PORT_PRESENT)) chk (.*);

// >>> dv/pin_partner.sv
// external circuitry on the port pins: drivers, pull-ups and floating lines
`timescale 1ns/1ps
module pin_partner (
  input  wire logic       clock,
  input  wire logic [7:0] pinOut,
  input  wire logic [7:0] pinOe,
  input  wire logic [7:0] pullupOn,
  input  wire logic [7:0] extLevel,
  input  wire logic [7:0] extEn,
  output logic      [7:0] pinLevel
);
  logic [7:0] floatLevel = 8'h00;
  // an undriven, unpulled line keeps toggling so it never reads as stable
  always @(posedge clock) floatLevel <= ~floatLevel;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pinOe[i])
        pinLevel[i] = pinOut[i];
      else if (extEn[i])
        pinLevel[i] = extLevel[i];
      else if (pullupOn[i])
        pinLevel[i] = 1'b1;
      else
        pinLevel[i] = floatLevel[i];
    end
  end
endmodule

// >>> dv/tb_top.sv
// self-checking bench for the port block with a reference model and pin partner
`timescale 1ns/1ps
module tb_top;
  import gpio_port_pkg::*;
  logic              clock = 1'b0;
  logic              sys_rst = 1'b1;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = 12'h000;
  logic [DATA_W-1:0] pwdata = 32'h0;
  logic [DATA_W-1:0] prdata;
  logic [3:0]        pstrb = 4'hF;
  logic              pready, pslverr, mPu, err;
  logic [7:0]        pinIn, pinOut, pinOe, pullupOn, segmentActive;
  logic [7:0]        segmentDrive = 8'h00, extLevel = 8'h00, extEn = 8'h00;
  logic [7:0]        mLat, mDir, mSeg, rd, expOe, expOut, expPu, expAct;
  logic [DATA_W-1:0] bareRdata;
  logic              bareReady, bareErr, errBare, rdyBare;
  logic [7:0]        barePinOut, barePinOe, barePullup, bareSegAct, rdBare;
  logic [31:0]       rnd = 32'h99885CEC;
  int                n_fail = 0, compares = 0, cyc = 0;
  int                segIdx [8] = '{0, 1, 2, 3, 7, 6, 5, 4};

  gpio_port_j dut (.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
    .pullupOn(pullupOn), .segmentDrive(segmentDrive), .segmentActive(segmentActive));
  pin_partner partner (.clock(clock), .pinOut(pinOut), .pinOe(pinOe), .pullupOn(pullupOn),
    .extLevel(extLevel), .extEn(extEn), .pinLevel(pinIn));
  // second copy built without the port: same bus, shared pin levels
  gpio_port_j #(.PORT_PRESENT(1'b0)) bareDut (.clock(clock), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(bareRdata), .pready(bareReady), .pslverr(bareErr), .pinIn(pinIn),
    .pinOut(barePinOut), .pinOe(barePinOe), .pullupOn(barePullup),
    .segmentDrive(segmentDrive), .segmentActive(bareSegAct));

  initial begin
    forever #20 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      finish_test();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic apb(input logic isWr, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= isWr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    rdBare = bareRdata[7:0];
    errBare = bareErr;
    rdyBare = bareReady;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
    check(err, a > ADDR_SEG_ENABLE);
    check(errBare, a > ADDR_SEG_ENABLE);
    if (pstrb[0]) begin
      case (a)
        ADDR_PIN_STATE, ADDR_OUT_LATCH: mLat = d;
        ADDR_DIRECTION: mDir = d;
        ADDR_PORT_G: mPu = d[SHARED_PULLUP_BIT];
        ADDR_SEG_ENABLE: mSeg = d;
        default: ;
      endcase
    end
  endtask
  task automatic rdChk(input logic [ADDR_W-1:0] a, input logic [7:0] e, input logic [7:0] m);
    apb(1'b0, a, 8'h00);
    check(rd & m, e & m);
    check(rdBare & m, ((a == ADDR_PORT_G) ? 8'h00 : e) & m);
    check(rdyBare, 1'b1);
  endtask
  task automatic pinsChk();
    repeat (3) @(posedge clock);
    for (int i = 0; i < 8; i++) begin
      expAct[i] = (i != 0) && mSeg[segIdx[i]];
      expOe[i] = expAct[i] || !mDir[i];
      expOut[i] = expAct[i] ? segmentDrive[segIdx[i]] : mLat[i];
      expPu[i] = mPu && !expOe[i];
    end
    check(segmentActive, expAct);
    check(pinOe, expOe);
    check(pinOut & expOe, expOut & expOe);
    check(pullupOn, expPu);
    check(barePullup, 8'h00);
    check(barePinOe, expOe);
    check(barePinOut & expOe, expOut & expOe);
    check(bareSegAct, expAct);
    rdChk(ADDR_PIN_STATE, (expOe & expOut) | (~expOe & extEn & extLevel) | (~expOe & ~extEn),
      expOe | extEn | expPu);
    rdChk(ADDR_OUT_LATCH, mLat, 8'hFF);
    rdChk(ADDR_DIRECTION, mDir, 8'hFF);
    rdChk(ADDR_SEG_ENABLE, mSeg, 8'hFF);
    rdChk(ADDR_PORT_G, {2'b0, mPu, 5'b0}, 8'hFF);
  endtask
  task automatic doReset();
    sys_rst <= 1'b1;
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    mLat = 8'h00;
    mDir = 8'hFF;
    mSeg = 8'h00;
    mPu = 1'b0;
    @(posedge clock);
    pinsChk();
    $display("test reset done");
  endtask

  initial begin
    doReset();
    for (int t = 0; t < 60; t++) begin
      rnd = lfsr(rnd);
      pstrb <= {3'h0, rnd[0] | rnd[1]};
      segmentDrive <= rnd[15:8];
      extLevel <= rnd[23:16];
      extEn <= rnd[31:24];
      wr({7'h0, 3'(rnd[4:2] % 6), 2'h0}, rnd[27:20]);
      pinsChk();
    end
    $display("test random done");
    rdChk(12'h014, 8'h00, 8'hFF);
    check(err, 1'b1);
    check(errBare, 1'b1);
    $display("test unmapped done");
    doReset();
    finish_test();
  end
endmodule
